/* File: verilog/cssc_pkg.sv */
// Purpose: shared constants, types and decode functions of the clock source startup control
// Assumes: fuse encodings use one as unprogrammed and zero as programmed
// Notes:   register offsets are byte addresses on a 32-bit apb slave
`default_nettype none
package cssc_pkg;

  // ===========================================================
  // register map
  localparam logic [7:0] FUSE_OFFSET    = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET  = 8'h08;

  // fuse register: [3:0] select, [5:4] startup time, [6] amplifier mode
  localparam int FUSE_SUT_LSB   = 4;
  localparam int FUSE_AMP_BIT   = 6;
  localparam int FUSE_W         = 7;
  // control register: [0] sleep request (self clearing), [2:1] sleep mode
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_MODE_LSB  = 1;
  // status register fields
  localparam int STAT_RUN_BIT   = 3;
  localparam int STAT_RANGE_LSB = 4;
  localparam int STAT_SWING_BIT = 6;
  localparam int STAT_STATE_LSB = 7;

  // ===========================================================
  // fuse layout and shipped default
  typedef struct packed {
    logic       amplifier_mode_fuse;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } cssc_fuses_t;

  localparam logic [3:0]  SHIPPED_SELECT = 4'h1;
  localparam logic [1:0]  SHIPPED_SUT    = 2'h2;
  localparam cssc_fuses_t FUSE_DEFAULT   = '{1'b1, SHIPPED_SUT, SHIPPED_SELECT};

  // select code boundaries
  localparam logic [3:0] SEL_XTAL_LOW   = 4'ha;
  localparam logic [3:0] SEL_LFXTAL     = 4'h9;
  localparam logic [3:0] SEL_EXTRC_LOW  = 4'h5;
  localparam logic [3:0] SEL_INTRC_LOW  = 4'h1;
  localparam logic [3:0] SEL_EXTCLK     = 4'h0;

  // crystal_range_select codes
  localparam logic [2:0] RANGE_CODE_LOW = 3'h5;
  localparam logic [2:0] RANGE_CODE_MID = 3'h6;

  // ===========================================================
  // enumerations
  typedef enum logic [2:0] {SRC_XTAL, SRC_LFXTAL, SRC_EXTRC, SRC_INTRC, SRC_EXTCLK} cssc_src_t;
  typedef enum logic [1:0] {RANGE_0P4_0P9, RANGE_0P9_3P0, RANGE_3P0_8P0, RANGE_WIDE} cssc_range_t;
  typedef enum logic [2:0] {WAKE_6, WAKE_18, WAKE_258, WAKE_1K, WAKE_16K, WAKE_32K} cssc_wake_t;
  typedef enum logic [1:0] {DELAY_NONE, DELAY_4K, DELAY_64K} cssc_delay_t;
  typedef enum logic [1:0] {MODE_IDLE, MODE_CONVERTER, MODE_POWER_DOWN, MODE_POWER_SAVE} cssc_mode_t;

  typedef struct packed {
    logic core_clock;
    logic io_clock;
    logic flash_interface_clock;
    logic converter_clock;
    logic async_timer_clock;
  } cssc_clocks_t;

  // ===========================================================
  // timing: counts in cycles of the oscillator being counted
  localparam int CNT_W         = 17;
  localparam int WAKE_6_CYC    = 6;
  localparam int WAKE_18_CYC   = 18;
  localparam int WAKE_258_CYC  = 258;
  localparam int WAKE_1K_CYC   = 1024;
  localparam int OSC_W         = 5;

  // ===========================================================
  // decode functions
  function automatic cssc_src_t decode_source(input logic [3:0] sel);
    if (sel >= SEL_XTAL_LOW)       return SRC_XTAL;
    else if (sel == SEL_LFXTAL)    return SRC_LFXTAL;
    else if (sel >= SEL_EXTRC_LOW) return SRC_EXTRC;
    else if (sel >= SEL_INTRC_LOW) return SRC_INTRC;
    else                           return SRC_EXTCLK;
  endfunction : decode_source

  function automatic cssc_wake_t decode_wake(input cssc_src_t src, input logic b0,
                                             input logic [1:0] sut);
    unique case (src)
      SRC_XTAL:   return (!b0 && !sut[1]) ? WAKE_258 :
                         ((!b0 || sut == 2'h0) ? WAKE_1K : WAKE_16K);
      SRC_LFXTAL: return sut[1] ? WAKE_32K : WAKE_1K;
      SRC_EXTRC:  return (sut == 2'h3) ? WAKE_6 : WAKE_18;
      default:    return WAKE_6;
    endcase
  endfunction : decode_wake

  function automatic cssc_delay_t decode_delay(input cssc_src_t src, input logic b0,
                                               input logic [1:0] sut);
    logic [2:0] key;
    key = {b0, sut};
    unique case (src)
      SRC_XTAL:
        unique case (key)
          3'h0, 3'h3, 3'h6: return DELAY_4K;
          3'h2, 3'h5:       return DELAY_NONE;
          default:          return DELAY_64K;
        endcase
      SRC_LFXTAL: return (sut == 2'h0) ? DELAY_4K : DELAY_64K;
      SRC_EXTRC:
        unique case (sut)
          2'h0:    return DELAY_NONE;
          2'h2:    return DELAY_64K;
          default: return DELAY_4K;
        endcase
      default:
        unique case (sut)
          2'h0:    return DELAY_NONE;
          2'h1:    return DELAY_4K;
          default: return DELAY_64K;
        endcase
    endcase
  endfunction : decode_delay

endpackage : cssc_pkg
`default_nettype wire

/* File: verilog/cssc_cycle_counter.sv */
// Purpose: counts rising edges of a sampled oscillator level up to a target
// Assumes: osc_level is already synchronised to clk
// Notes:   a zero target finishes one cycle after start
`timescale 1ns/1ps
`default_nettype none
module cssc_cycle_counter #(
  parameter int WIDTH = 17
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic             osc_level,
  input  wire logic [WIDTH-1:0] target,
  output logic                  busy,
  output logic                  done
);

  logic             prev_level;
  logic [WIDTH-1:0] count;
  wire              osc_rise   = osc_level & ~prev_level;
  wire [WIDTH-1:0]  next_count = count + 1'b1;
  wire              reached    = busy & osc_rise & (next_count == target);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prev_level <= 1'b0;
      count      <= '0;
      busy       <= 1'b0;
      done       <= 1'b0;
    end
    else
    begin
      prev_level <= osc_level;
      done       <= (start & (target == '0)) | reached;
      if (start)
      begin
        count <= '0;
        busy  <= (target != '0);
      end
      else if (busy & osc_rise)
      begin
        count <= next_count;
        busy  <= ~reached;
      end
    end
  end

endmodule : cssc_cycle_counter
`default_nettype wire

/* File: verilog/cssc_clock_control.sv */
// Purpose: clock source selection from fuses, start-up timing and clock gating
// Assumes: oscillator inputs run well below half of core_clk and are sampled as levels
// Notes:   fuse changes act on the decode at once; a reset re-runs the start-up
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - codes 1111-1010 crystal, 1001 low-frequency crystal
// - decode remaining codes, route chosen clock
// - fuse bit one means unprogrammed
// - deep-sleep wake counts selected source cycles
// - reset adds no, 4K or 64K watchdog cycles
// - shipped fuses: select 0001, startup 10
// - crystal bits three to one pick range
// - crystal wake count from bit zero, startup
// - crystal reset delay from bit zero, startup
// - async timer clock runs through sleep
// - converter clock independent of core clock
// - flash clock gated with core clock
module cssc_clock_control #(
  parameter int RESET_SHORT_CYCLES = 4096,
  parameter int RESET_LONG_CYCLES  = 65536,
  parameter int WAKE_16K_CYCLES    = 16384,
  parameter int WAKE_32K_CYCLES    = 32768
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [cssc_pkg::OSC_W-1:0]  osc_pins,
  input  wire logic                        watchdog_osc,
  input  wire logic                        async_xtal,
  input  wire logic                        wake_pin,
  output cssc_pkg::cssc_clocks_t           clocks
);

  // ===========================================================
  // pin synchronisers
  typedef enum logic [1:0] {ST_POR, ST_START, ST_RUN, ST_SLEEP} cssc_state_t;

  logic [cssc_pkg::OSC_W-1:0] osc_meta;
  logic [cssc_pkg::OSC_W-1:0] osc_sync;
  logic [2:0]                 misc_meta;
  logic [2:0]                 misc_sync;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      osc_meta  <= '0;
      osc_sync  <= '0;
      misc_meta <= '0;
      misc_sync <= '0;
    end
    else
    begin
      osc_meta  <= osc_pins;
      osc_sync  <= osc_meta;
      misc_meta <= {wake_pin, async_xtal, watchdog_osc};
      misc_sync <= misc_meta;
    end
  end

  wire wdt_level   = misc_sync[0];
  wire async_level = misc_sync[1];
  wire wake_level  = misc_sync[2];

  // ===========================================================
  // fuse and control registers
  cssc_pkg::cssc_fuses_t fuses;
  cssc_pkg::cssc_mode_t  sleep_mode;
  cssc_state_t           state;

  // writes land only on the edge at which the master sees pready
  wire       complete    = psel & penable & pready;
  wire       access      = psel & penable & ~pready;
  wire       hit_fuse    = (paddr == cssc_pkg::FUSE_OFFSET);
  wire       hit_ctrl    = (paddr == cssc_pkg::CONTROL_OFFSET);
  wire       hit_stat    = (paddr == cssc_pkg::STATUS_OFFSET);
  wire       mapped      = hit_fuse | hit_ctrl | hit_stat;
  wire       wr_fuse     = complete & pwrite & hit_fuse;
  wire       wr_ctrl     = complete & pwrite & hit_ctrl;
  wire       sleep_req   = wr_ctrl & pwdata[cssc_pkg::CTRL_SLEEP_BIT];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      fuses      <= cssc_pkg::FUSE_DEFAULT;
      sleep_mode <= cssc_pkg::MODE_IDLE;
    end
    else
    begin
      if (wr_fuse)
        fuses <= pwdata[cssc_pkg::FUSE_W-1:0];
      if (wr_ctrl)
        sleep_mode <= cssc_pkg::cssc_mode_t'(pwdata[cssc_pkg::CTRL_MODE_LSB +: 2]);
    end
  end

  // ===========================================================
  // fuse decode
  wire [3:0] sel_code = fuses.clock_source_select_fuses;
  wire [2:0] crystal_range_select = sel_code[3:1];
  wire       crystal_startup_select_bit = sel_code[0];
  wire       full_swing = ~fuses.amplifier_mode_fuse;

  cssc_pkg::cssc_src_t   source;
  cssc_pkg::cssc_range_t range;
  cssc_pkg::cssc_wake_t  wake_sel;
  cssc_pkg::cssc_delay_t delay_sel;

  assign source    = cssc_pkg::decode_source(sel_code);
  assign range     = full_swing ? cssc_pkg::RANGE_WIDE :
                     (crystal_range_select == cssc_pkg::RANGE_CODE_LOW) ? cssc_pkg::RANGE_0P4_0P9 :
                     (crystal_range_select == cssc_pkg::RANGE_CODE_MID) ? cssc_pkg::RANGE_0P9_3P0 :
                     cssc_pkg::RANGE_3P0_8P0;
  assign wake_sel  = cssc_pkg::decode_wake(source, crystal_startup_select_bit,
                                           fuses.startup_time_fuses);
  assign delay_sel = cssc_pkg::decode_delay(source, crystal_startup_select_bit,
                                            fuses.startup_time_fuses);

  wire selected_level = osc_sync[source];

  logic [cssc_pkg::CNT_W-1:0] wake_target;
  logic [cssc_pkg::CNT_W-1:0] delay_target;

  always_comb
  begin
    unique case (wake_sel)
      cssc_pkg::WAKE_6:   wake_target = cssc_pkg::CNT_W'(cssc_pkg::WAKE_6_CYC);
      cssc_pkg::WAKE_18:  wake_target = cssc_pkg::CNT_W'(cssc_pkg::WAKE_18_CYC);
      cssc_pkg::WAKE_258: wake_target = cssc_pkg::CNT_W'(cssc_pkg::WAKE_258_CYC);
      cssc_pkg::WAKE_1K:  wake_target = cssc_pkg::CNT_W'(cssc_pkg::WAKE_1K_CYC);
      cssc_pkg::WAKE_16K: wake_target = cssc_pkg::CNT_W'(WAKE_16K_CYCLES);
      default:            wake_target = cssc_pkg::CNT_W'(WAKE_32K_CYCLES);
    endcase
  end

  always_comb
  begin
    unique case (delay_sel)
      cssc_pkg::DELAY_4K:  delay_target = cssc_pkg::CNT_W'(RESET_SHORT_CYCLES);
      cssc_pkg::DELAY_64K: delay_target = cssc_pkg::CNT_W'(RESET_LONG_CYCLES);
      default:             delay_target = '0;
    endcase
  end

  // ===========================================================
  // start-up counters
  logic por_kick;
  logic por_busy;
  logic por_done;
  logic src_busy;
  logic src_done;

  wire deep_mode = (sleep_mode == cssc_pkg::MODE_POWER_DOWN) |
                   (sleep_mode == cssc_pkg::MODE_POWER_SAVE);
  // reset delay first, then the source count, as a wake would
  wire src_start = ((state == ST_POR) & por_done) |
                   ((state == ST_SLEEP) & wake_level & deep_mode);

  // watchdog delay counts on the synchronised level so its end is already in core_clk
  cssc_cycle_counter #(
    .WIDTH (cssc_pkg::CNT_W)
  ) u_reset_delay (
    .clk       (core_clk),
    .reset     (reset),
    .start     (por_kick),
    .osc_level (wdt_level),
    .target    (delay_target),
    .busy      (por_busy),
    .done      (por_done)
  );

  cssc_cycle_counter #(
    .WIDTH (cssc_pkg::CNT_W)
  ) u_wake_count (
    .clk       (core_clk),
    .reset     (reset),
    .start     (src_start),
    .osc_level (selected_level),
    .target    (wake_target),
    .busy      (src_busy),
    .done      (src_done)
  );

  // ===========================================================
  // sequencer
  cssc_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_POR:   if (por_done) next_state = ST_START;
      ST_START: if (src_done) next_state = ST_RUN;
      ST_RUN:   if (sleep_req) next_state = ST_SLEEP;
      ST_SLEEP: if (wake_level) next_state = deep_mode ? ST_START : ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state    <= ST_POR;
      por_kick <= 1'b1;
    end
    else
    begin
      state    <= next_state;
      por_kick <= 1'b0;
    end
  end

  // ===========================================================
  // clock gating
  wire run_core = (state == ST_RUN);
  wire run_io   = run_core | ((state == ST_SLEEP) & (sleep_mode == cssc_pkg::MODE_IDLE));
  wire run_conv = run_io | ((state == ST_SLEEP) & (sleep_mode == cssc_pkg::MODE_CONVERTER));

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      clocks <= '0;
    else
    begin
      clocks.core_clock            <= selected_level & run_core;
      clocks.flash_interface_clock <= selected_level & run_core;
      clocks.io_clock              <= selected_level & run_io;
      clocks.converter_clock       <= selected_level & run_conv;
      clocks.async_timer_clock     <= async_level;
    end
  end

  // ===========================================================
  // apb response, one wait state
  logic [31:0] read_word;

  always_comb
  begin
    read_word = '0;
    if (hit_fuse)
      read_word[cssc_pkg::FUSE_W-1:0] = fuses;
    else if (hit_ctrl)
      read_word[cssc_pkg::CTRL_MODE_LSB +: 2] = sleep_mode;
    else if (hit_stat)
    begin
      read_word[2:0]                           = source;
      read_word[cssc_pkg::STAT_RUN_BIT]        = run_core;
      read_word[cssc_pkg::STAT_RANGE_LSB +: 2] = range;
      read_word[cssc_pkg::STAT_SWING_BIT]      = full_swing;
      read_word[cssc_pkg::STAT_STATE_LSB +: 2] = state;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= (access & ~pwrite) ? read_word : '0;
    end
  end

  // ===========================================================
  // checks
  a_por_holds_core: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_POR) |=> !clocks.core_clock) else $error("core clock during reset delay");
  a_wake_after_count: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_START && next_state == ST_RUN) |-> src_done) else $error("early release");
  a_shipped_fuses: assert property (@(posedge core_clk)
    $fell(reset) |-> fuses == cssc_pkg::FUSE_DEFAULT) else $error("fuse default wrong");
  a_src_lfxtal: assert property (@(posedge core_clk) disable iff (reset)
    (sel_code == cssc_pkg::SEL_LFXTAL) |-> source == cssc_pkg::SRC_LFXTAL)
    else $error("1001 not low-frequency crystal");
  a_src_extclk: assert property (@(posedge core_clk) disable iff (reset)
    (sel_code == cssc_pkg::SEL_EXTCLK) |-> source == cssc_pkg::SRC_EXTCLK)
    else $error("0000 not external clock");
  a_swing_polarity: assert property (@(posedge core_clk) disable iff (reset)
    full_swing == !fuses.amplifier_mode_fuse) else $error("fuse polarity");
  a_range_low: assert property (@(posedge core_clk) disable iff (reset)
    (fuses.amplifier_mode_fuse && crystal_range_select == cssc_pkg::RANGE_CODE_LOW)
    |-> range == cssc_pkg::RANGE_0P4_0P9) else $error("crystal range");
  a_xtal_wake258: assert property (@(posedge core_clk) disable iff (reset)
    (source == cssc_pkg::SRC_XTAL && {crystal_startup_select_bit, fuses.startup_time_fuses}
     == 3'h1) |-> wake_target == cssc_pkg::CNT_W'(cssc_pkg::WAKE_258_CYC))
    else $error("crystal wake count");
  a_xtal_nodelay: assert property (@(posedge core_clk) disable iff (reset)
    (source == cssc_pkg::SRC_XTAL && {crystal_startup_select_bit, fuses.startup_time_fuses}
     == 3'h5) |-> delay_target == '0) else $error("crystal reset delay");
  a_flash_core: assert property (@(posedge core_clk) disable iff (reset)
    clocks.flash_interface_clock == clocks.core_clock) else $error("flash clock split");
  a_async_sleep: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_SLEEP) |=> clocks.async_timer_clock == $past(async_level))
    else $error("async clock stopped");
  a_conv_runs: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_SLEEP && sleep_mode == cssc_pkg::MODE_CONVERTER && selected_level)
    |=> clocks.converter_clock && !clocks.core_clock) else $error("converter clock");
  a_por_sync: assert property (@(posedge core_clk) disable iff (reset)
    $rose(por_done) |-> !por_busy) else $error("delay end unsynchronised");
  a_wake_counting: assert property (@(posedge core_clk) disable iff (reset)
    (state == ST_START && !src_done) |-> src_busy) else $error("wake count idle");

  c_reset_to_run: cover property (@(posedge core_clk) disable iff (reset)
    state == ST_START ##1 state == ST_RUN);
  c_deep_wake: cover property (@(posedge core_clk) disable iff (reset)
    state == ST_SLEEP && deep_mode && wake_level);
  c_fuse_write: cover property (@(posedge core_clk) disable iff (reset) wr_fuse);

endmodule : cssc_clock_control
`default_nettype wire

/* File: sim/cssc_clock_control_bench.sv */
// Purpose: self-checking bench of the clock source startup control
// Assumes: oscillator levels are driven slowly, eight core cycles per period
// Notes:   small start-up counts keep the run short; reset always reloads the shipped fuses
`timescale 1ns/1ps
`default_nettype none
module cssc_clock_control_bench;
  // ===========================================================
  // signals
  localparam int RST_SHORT = 8;
  localparam int RST_LONG  = 16;
  localparam int WAKE_16K  = 20;
  localparam int WAKE_32K  = 24;
  localparam int WDOG_IDX  = 5;
  logic                         core_clk     = 1'b0;
  logic                         reset        = 1'b1;
  logic                         psel         = 1'b0;
  logic                         penable      = 1'b0;
  logic                         pwrite       = 1'b0;
  logic [7:0]                   paddr        = 8'h00;
  logic [31:0]                  pwdata       = 32'h0;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic [cssc_pkg::OSC_W-1:0]   osc_pins     = '0;
  logic                         watchdog_osc = 1'b0;
  logic                         async_xtal   = 1'b0;
  logic                         wake_pin     = 1'b0;
  cssc_pkg::cssc_clocks_t       clocks;
  int                           fail_count   = 0;
  int                           check_count  = 0;
  logic                         seen_core    = 1'b0;
  logic                         seen_conv    = 1'b0;
  logic                         seen_io      = 1'b0;
  // wake counts indexed by {bit zero, startup fuses}
  int wake_tab [8] = '{258, 258, 1024, 1024, 1024, WAKE_16K, WAKE_16K, WAKE_16K};

  always #12.5 core_clk = ~core_clk;

  cssc_clock_control #(
    .RESET_SHORT_CYCLES (RST_SHORT),
    .RESET_LONG_CYCLES  (RST_LONG),
    .WAKE_16K_CYCLES    (WAKE_16K),
    .WAKE_32K_CYCLES    (WAKE_32K)
  ) dut (
    .core_clk     (core_clk),
    .reset        (reset),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .osc_pins     (osc_pins),
    .watchdog_osc (watchdog_osc),
    .async_xtal   (async_xtal),
    .wake_pin     (wake_pin),
    .clocks       (clocks)
  );

  // ===========================================================
  // compare and bus tasks
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, wdata, d, e);
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [31:0] d);
    logic e;
    apb(1'b0, addr, 32'h0, d, e);
  endtask : rd

  // one slow oscillator period per count; index five is the watchdog oscillator
  task automatic pulse_osc(input int idx, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      if (idx == WDOG_IDX) watchdog_osc <= 1'b1;
      else osc_pins[idx] <= 1'b1;
      repeat (3) @(posedge core_clk);
      if (idx == WDOG_IDX) watchdog_osc <= 1'b0;
      else osc_pins[idx] <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : pulse_osc

  function automatic logic [2:0] exp_src(input logic [3:0] sel);
    if (sel >= 4'ha) return 3'h0;
    if (sel == 4'h9) return 3'h1;
    if (sel >= 4'h5) return 3'h2;
    if (sel >= 4'h1) return 3'h3;
    return 3'h4;
  endfunction : exp_src

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ===========================================================
  // clock output monitor
  always @(posedge core_clk)
  begin
    if (!reset)
    begin
      if (clocks.core_clock === 1'b1) seen_core = 1'b1;
      if (clocks.converter_clock === 1'b1) seen_conv = 1'b1;
      if (clocks.io_clock === 1'b1) seen_io = 1'b1;
      chk_bit("flash clock", clocks.core_clock, clocks.flash_interface_clock);
    end
  end

  initial
  begin
    repeat (80000) @(posedge core_clk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    stop_test();
  end

  // ===========================================================
  // tests
  initial
  begin
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
    logic        amp;
    logic [3:0]  sel;
    logic [1:0]  mode;
    void'($urandom(32'h380d));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd(cssc_pkg::FUSE_OFFSET, d);
    chk_word("fuse reset", 32'h61, d);
    rd(cssc_pkg::STATUS_OFFSET, d);
    chk_word("shipped source", 32'h3, {29'h0, d[2:0]});
    pulse_osc(WDOG_IDX, RST_LONG - 1);
    rd(cssc_pkg::STATUS_OFFSET, d);
    chk_bit("running early", 1'b0, d[3]);
    pulse_osc(WDOG_IDX, 1);
    pulse_osc(3, 5);
    rd(cssc_pkg::STATUS_OFFSET, d);
    chk_bit("running early", 1'b0, d[3]);
    pulse_osc(3, 1);
    rd(cssc_pkg::STATUS_OFFSET, d);
    chk_word("state run", 32'h2, {30'h0, d[8:7]});
    $display("test reset startup done");

    for (int s = 0; s < 16; s++)
    begin
      sel = s[3:0];
      amp = 1'($urandom() % 2);
      wr(cssc_pkg::FUSE_OFFSET, {25'h0, amp, 2'h2, sel});
      rd(cssc_pkg::STATUS_OFFSET, d);
      chk_word("source", {29'h0, exp_src(sel)}, {29'h0, d[2:0]});
      if (s >= 10)
      begin
        r = amp ? {30'h0, 2'(sel[3:1] - 3'h5)} : 32'h3;
        chk_word("range", r, {30'h0, d[5:4]});
        chk_bit("full swing", ~amp, d[6]);
      end
    end
    repeat (4)
    begin
      r = $urandom();
      wr(cssc_pkg::FUSE_OFFSET, r);
      rd(cssc_pkg::FUSE_OFFSET, d);
      chk_word("fuse readback", r & 32'h7f, d);
    end
    apb(1'b0, 8'h0c, 32'h0, d, e);
    chk_bit("unmapped error", 1'b1, e);
    chk_word("unmapped data", 32'h0, d);
    $display("test decode done");

    for (int k = 0; k < 8; k++)
    begin
      wr(cssc_pkg::FUSE_OFFSET, {25'h0, 1'b1, 2'(k), 3'h7, k[2]});
      mode = k[0] ? 2'h3 : 2'h2;
      wr(cssc_pkg::CONTROL_OFFSET, {29'h0, mode, 1'b1});
      rd(cssc_pkg::STATUS_OFFSET, d);
      chk_word("state sleep", 32'h3, {30'h0, d[8:7]});
      async_xtal <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk_bit("async clock", 1'b1, clocks.async_timer_clock);
      async_xtal <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk_bit("async clock", 1'b0, clocks.async_timer_clock);
      wake_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      wake_pin <= 1'b0;
      pulse_osc(0, wake_tab[k] - 1);
      rd(cssc_pkg::STATUS_OFFSET, d);
      chk_bit("running early", 1'b0, d[3]);
      chk_bit("core clock", 1'b0, clocks.core_clock);
      pulse_osc(0, 1);
      rd(cssc_pkg::STATUS_OFFSET, d);
      chk_bit("running", 1'b1, d[3]);
    end
    $display("test deep sleep wake done");

    // pass 0 sleeps in converter mode, pass 1 in idle mode
    for (int m = 0; m < 2; m++)
    begin
      wr(cssc_pkg::CONTROL_OFFSET, {29'h0, 1'b0, (m == 0), 1'b1});
      repeat (4) @(posedge core_clk);
      seen_core = 1'b0;
      seen_io   = 1'b0;
      seen_conv = 1'b0;
      pulse_osc(0, 4);
      chk_bit("core halted", 1'b0, seen_core);
      chk_bit("io clock", m[0], seen_io);
      chk_bit("converter runs", 1'b1, seen_conv);
      wake_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      wake_pin <= 1'b0;
      rd(cssc_pkg::STATUS_OFFSET, d);
      chk_word("state run", 32'h2, {30'h0, d[8:7]});
      seen_core = 1'b0;
      pulse_osc(0, 4);
      chk_bit("core runs", 1'b1, seen_core);
    end
    $display("test shallow sleep done");
    stop_test();
  end
endmodule : cssc_clock_control_bench
`default_nettype wire
